/* File: verilog/csp_pkg.sv */
// shared constants and types for the codec serial audio port
package csp_pkg;
  localparam int unsigned CORE_CLK_MHZ = 125;
  localparam int unsigned SCLK_HALF_NS = 40;
  // longest half period: rounds down, never below one cycle
  localparam int unsigned SCLK_HALF_RAW = (SCLK_HALF_NS * CORE_CLK_MHZ) / 1000;
  localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_RAW < 1) ? 1 : SCLK_HALF_RAW;
  localparam int unsigned SLOT_BITS = 16;
  localparam logic [5:0] FRAME_LAST_64 = 6'h3f;
  localparam logic [5:0] FRAME_LAST_32 = 6'h1f;
  localparam logic [5:0] HALF_MASK_64 = 6'h1f;
  localparam logic [5:0] HALF_MASK_32 = 6'h0f;
  localparam logic [5:0] HALF_64 = 6'h20;
  localparam logic [5:0] HALF_32 = 6'h10;
  localparam logic [5:0] SLOT_END = 6'h10;
  localparam logic [5:0] SLOT_LAST = 6'h0f;
  // framing select codes
  localparam logic [1:0] SF_64_PULSE = 2'h0;
  localparam logic [1:0] SF_64_LEVEL = 2'h1;
  localparam logic [1:0] SF_32_LEVEL = 2'h2;
  // audio data format codes
  localparam logic [1:0] DF_16 = 2'h0;
  localparam logic [1:0] DF_8 = 2'h1;
  localparam logic [1:0] DF_4 = 2'h2;
  localparam logic [15:0] MASK_16 = 16'hffff;
  localparam logic [15:0] MASK_8 = 16'hff00;
  localparam logic [15:0] MASK_4 = 16'hf000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } csp_frame_t;

  typedef enum {
    CSP_OFF,
    CSP_RUN
  } csp_state_t;
endpackage

/* File: verilog/csp_sclk_gen.sv */
// bit clock divider with registered edge pulses
`timescale 1ns/1ps
module csp_sclk_gen import csp_pkg::*; #(
  parameter int unsigned HALF_CYC = SCLK_HALF_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic run_i,
  // bit clock and its edges
  output logic sclk_o,
  output logic rise_o,
  output logic fall_o
);
  localparam logic [15:0] CNT_LAST = 16'(HALF_CYC - 1);
  logic [15:0] cnt;

  if (HALF_CYC < 1 || HALF_CYC > 65536) begin : g_bad_half
    $error("half period out of range");
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 16'h0000;
      sclk_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else if (!run_i) begin
      // stopped clock parks low
      cnt <= 16'h0000;
      sclk_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else if (cnt == CNT_LAST) begin
      cnt <= 16'h0000;
      sclk_o <= !sclk_o;
      rise_o <= !sclk_o;
      fall_o <= sclk_o;
    end else begin
      cnt <= cnt + 16'h0001;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end
  end
endmodule

/* File: verilog/csp_serial_port.sv */
// serial audio port: bit clock, frame sync, capture out, playback in
// Behaviour
// - with the port enabled, frame sync marks the start of every frame.
// - frame sync is a one-bit pulse before the frame or high for the left word.
// - with the port disabled, frame sync is held low.
// - serial input is sampled at bit clock falling edges.
// - received samples go on to the playback converter path.
// - each word fills a 16-bit slot, msb first aligned, zeros after the lsb.
// - three framing formats are selectable and all data formats are carried.
// - serial input is accepted only while the port is enabled.
// - a frame holds 64 or 32 bit clocks depending on the format.
// - capture bits leave on the serial output at bit clock rising edges.
// - with the port disabled, bit clock and serial output are held low.
`timescale 1ns/1ps
module csp_serial_port import csp_pkg::*; #(
  parameter int unsigned HALF_CYC = SCLK_HALF_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // configuration, same clock domain
  input wire logic serial_port_enable_bit_i,
  input wire logic [1:0] frame_fmt_i,
  input wire logic [1:0] data_fmt_i,
  // capture samples from the converters
  input wire csp_frame_t cap_frame_i,
  output logic cap_take_o,
  // playback samples to the converters
  output csp_frame_t pb_frame_o,
  output logic pb_valid_o,
  // serial pins
  input wire logic serial_data_in_i,
  output logic serial_clk_o,
  output logic frame_sync_out_o,
  output logic serial_data_out_o
);
  logic [1:0] rst_pipe;
  logic rst_n;
  logic [1:0] serial_data_in_pipe;
  logic serial_data_in_s;
  csp_state_t state;
  logic sclk_rise;
  logic sclk_fall;
  logic [1:0] fmt;
  logic [1:0] dfmt;
  logic [1:0] fmt_pend;
  logic [1:0] dfmt_pend;
  logic [5:0] bit_cnt;
  logic [15:0] rx_sh;
  logic [15:0] pb_left_hold;
  csp_frame_t tx;
  logic [5:0] frame_last;
  logic [5:0] half_mask;
  logic [5:0] half;
  logic [15:0] dmask;
  logic [5:0] next_bit;
  logic [5:0] next_pos;
  logic [5:0] cur_pos;
  logic cur_right;
  logic [15:0] rx_word;
  csp_frame_t cap_masked;
  csp_frame_t next_tx;
  logic [15:0] tx_word;

  // reset release through two flops
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // pin input is asynchronous to the core clock
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      serial_data_in_pipe <= 2'h0;
    end else begin
      serial_data_in_pipe <= {serial_data_in_pipe[0], serial_data_in_i};
    end
  end
  assign serial_data_in_s = serial_data_in_pipe[1];

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= CSP_OFF;
    end else begin
      case (state)
        CSP_OFF: begin
          if (serial_port_enable_bit_i) begin
            state <= CSP_RUN;
          end
        end
        CSP_RUN: begin
          if (!serial_port_enable_bit_i) begin
            state <= CSP_OFF;
          end
        end
        default: begin
          state <= CSP_OFF;
        end
      endcase
    end
  end

  csp_sclk_gen #(
    .HALF_CYC(HALF_CYC)
  ) u_sclk (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .run_i(state == CSP_RUN && serial_port_enable_bit_i),
    .sclk_o(serial_clk_o),
    .rise_o(sclk_rise),
    .fall_o(sclk_fall)
  );

  // frame geometry from the latched format
  always_comb begin
    if (fmt == SF_32_LEVEL) begin
      frame_last = FRAME_LAST_32;
      half_mask = HALF_MASK_32;
      half = HALF_32;
    end else begin
      frame_last = FRAME_LAST_64;
      half_mask = HALF_MASK_64;
      half = HALF_64;
    end
    case (dfmt)
      DF_8: dmask = MASK_8;
      DF_4: dmask = MASK_4;
      default: dmask = MASK_16;
    endcase
    next_bit = (bit_cnt >= frame_last) ? 6'h00 : bit_cnt + 6'h01;
    next_pos = next_bit & half_mask;
    cur_pos = bit_cnt & half_mask;
    cur_right = (bit_cnt >= half);
    rx_word = {rx_sh[14:0], serial_data_in_s} & dmask;
    cap_masked.left = cap_frame_i.left & dmask;
    cap_masked.right = cap_frame_i.right & dmask;
    next_tx = (next_bit == 6'h00) ? cap_masked : tx;
    tx_word = (next_bit >= half) ? next_tx.right : next_tx.left;
  end

  // formats only change between frames, so the counter never overruns
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fmt <= SF_64_PULSE;
      dfmt <= DF_16;
      fmt_pend <= SF_64_PULSE;
      dfmt_pend <= DF_16;
      bit_cnt <= FRAME_LAST_64;
    end else if (state != CSP_RUN) begin
      fmt <= frame_fmt_i;
      dfmt <= data_fmt_i;
      fmt_pend <= frame_fmt_i;
      dfmt_pend <= data_fmt_i;
      if (frame_fmt_i == SF_32_LEVEL) begin
        bit_cnt <= FRAME_LAST_32;
      end else if (frame_fmt_i == SF_64_LEVEL) begin
        bit_cnt <= FRAME_LAST_64;
      end else begin
        // one lead-in bit, so the first frame gets its pulse as well
        bit_cnt <= FRAME_LAST_64 - 6'h01;
      end
    end else if (sclk_rise) begin
      bit_cnt <= next_bit;
      if (next_bit == frame_last) begin
        fmt_pend <= frame_fmt_i;
        dfmt_pend <= data_fmt_i;
      end
    end else if (sclk_fall && bit_cnt == frame_last) begin
      // switch only once the last bit of the old frame is taken in
      fmt <= fmt_pend;
      dfmt <= dfmt_pend;
      bit_cnt <= (fmt_pend == SF_32_LEVEL) ? FRAME_LAST_32 : FRAME_LAST_64;
    end
  end

  // transmit side and frame sync, updated on bit clock rise
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx <= '0;
      cap_take_o <= 1'b0;
      serial_data_out_o <= 1'b0;
      frame_sync_out_o <= 1'b0;
    end else if (state != CSP_RUN || !serial_port_enable_bit_i) begin
      cap_take_o <= 1'b0;
      serial_data_out_o <= 1'b0;
      frame_sync_out_o <= 1'b0;
    end else if (sclk_rise) begin
      tx <= next_tx;
      cap_take_o <= (next_bit == 6'h00);
      if (next_pos < SLOT_END) begin
        serial_data_out_o <= tx_word[4'hf - next_pos[3:0]];
      end else begin
        serial_data_out_o <= 1'b0;
      end
      if (next_bit == frame_last) begin
        // the pulse announces the coming frame, so its format decides
        frame_sync_out_o <= frame_fmt_i != SF_64_LEVEL
                            && frame_fmt_i != SF_32_LEVEL;
      end else if (fmt == SF_64_LEVEL || fmt == SF_32_LEVEL) begin
        frame_sync_out_o <= (next_bit < half);
      end else begin
        frame_sync_out_o <= 1'b0;
      end
    end else begin
      cap_take_o <= 1'b0;
    end
  end

  // receive side, sampled on bit clock fall
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh <= WORD_ZERO;
      pb_left_hold <= WORD_ZERO;
      pb_frame_o <= '0;
      pb_valid_o <= 1'b0;
    end else if (state == CSP_RUN && serial_port_enable_bit_i
                 && sclk_fall && cur_pos < SLOT_END) begin
      rx_sh <= {rx_sh[14:0], serial_data_in_s};
      pb_valid_o <= 1'b0;
      if (cur_pos == SLOT_LAST && !cur_right) begin
        pb_left_hold <= rx_word;
      end else if (cur_pos == SLOT_LAST) begin
        pb_frame_o.left <= pb_left_hold;
        pb_frame_o.right <= rx_word;
        pb_valid_o <= 1'b1;
      end
    end else begin
      pb_valid_o <= 1'b0;
    end
  end

  // checks
  localparam int A_PER = 2 * HALF_CYC;
  logic [6:0] lvl_rises;
  logic level_fmt;
  assign level_fmt = (fmt != SF_64_PULSE);

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lvl_rises <= 7'h00;
    end else if (!frame_sync_out_o) begin
      lvl_rises <= 7'h00;
    end else if (sclk_rise) begin
      lvl_rises <= lvl_rises + 7'h01;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  a_frame_sync_out_off_low: assert property (
    !serial_port_enable_bit_i |=> !frame_sync_out_o
  ) else $error("frame sync high while disabled");
  a_pins_off_low: assert property (
    !serial_port_enable_bit_i |=> ##1 !serial_clk_o && !serial_data_out_o
  ) else $error("clock or data high while disabled");
  a_frame_sync_out_frame_start: assert property (
    state == CSP_RUN && serial_port_enable_bit_i && sclk_rise
    && level_fmt && next_bit == 6'h00 |=> frame_sync_out_o
  ) else $error("frame sync missing at frame start");
  a_pulse_one_bit: assert property (
    @(posedge core_clk_i) disable iff (!rst_n || !serial_port_enable_bit_i)
    $rose(frame_sync_out_o) && !level_fmt |-> ##A_PER $fell(frame_sync_out_o)
  ) else $error("pulse frame sync not one bit long");
  a_level_width: assert property (
    $fell(frame_sync_out_o) && serial_port_enable_bit_i && level_fmt
    |-> lvl_rises == {1'b0, half}
  ) else $error("level frame sync not one word long");
  a_frame_bound: assert property (
    bit_cnt <= frame_last
  ) else $error("bit counter beyond frame");
  a_serial_data_out_on_rise: assert property (
    $changed(serial_data_out_o) && serial_port_enable_bit_i |-> $past(sclk_rise)
  ) else $error("serial output moved off a rising edge");
  a_msb_first: assert property (
    state == CSP_RUN && serial_port_enable_bit_i && sclk_rise
    && next_bit == 6'h00 |=> serial_data_out_o == $past(cap_frame_i.left[15])
  ) else $error("slot did not start with msb");
  a_pad_zero: assert property (
    serial_data_out_o |-> next_pos < SLOT_END || cur_pos < SLOT_END
  ) else $error("padding bit not zero");
  a_rx_on_fall: assert property (
    $changed(rx_sh) |-> $past(sclk_fall)
  ) else $error("input sampled off a falling edge");
  a_rx_enabled: assert property (
    pb_valid_o |-> $past(serial_port_enable_bit_i) && $past(state == CSP_RUN)
  ) else $error("input accepted while disabled");
  a_pb_forward: assert property (
    pb_valid_o |-> $past(cur_right) && $past(cur_pos) == SLOT_LAST
    && pb_frame_o.right == $past(rx_word)
  ) else $error("playback word not forwarded");

  c_level_frame: cover property (
    $fell(frame_sync_out_o) && level_fmt && fmt == SF_64_LEVEL);
  c_short_frame: cover property (
    $fell(frame_sync_out_o) && fmt == SF_32_LEVEL);
  c_pulse_frame: cover property ($fell(frame_sync_out_o) && !level_fmt);
  c_playback: cover property (pb_valid_o && dfmt == DF_8);
endmodule

/* File: tb/csp_dsp_model.sv */
// behavioural model of the dsp on the far side of the serial port
`timescale 1ns/1ps
module csp_dsp_model import csp_pkg::*; (
  // pins of the port
  input wire logic serial_clk_i,
  input wire logic frame_sync_i,
  input wire logic serial_data_out_i,
  output logic serial_data_in_o,
  // run setup
  input wire logic active_i,
  input wire logic pulse_mode_i,
  input wire logic bits64_i,
  input wire csp_frame_t tx_frame_i,
  // results
  output csp_frame_t rx_frame_o,
  output logic pad_bad_o
);
  int cnt = -1;
  int half = 32;
  int pos = 0;
  logic sync_prev = 1'b0;
  initial begin
    serial_data_in_o = 1'b0;
    rx_frame_o = '0;
    pad_bad_o = 1'b0;
  end
  always @(negedge active_i) begin
    cnt = -1;
    sync_prev = 1'b0;
  end
  // sync lags the bit clock by a core cycle, so judge it 10 ns later
  // bits change after the rise and stand well past the fall
  always @(posedge serial_clk_i) begin
    #10;
    half = bits64_i ? 32 : 16;
    if (pulse_mode_i ? sync_prev : (frame_sync_i && !sync_prev)) cnt = 0;
    else if (cnt >= 0) cnt = (cnt + 1) % (2 * half);
    sync_prev = frame_sync_i;
    pos = cnt % half;
    // unsynced: a toggling line, never a stale copy
    if (cnt < 0) serial_data_in_o = ~serial_data_in_o;
    else if (pos >= 16) serial_data_in_o = 1'b0;
    else if (cnt < half) serial_data_in_o = tx_frame_i.left[15 - pos];
    else serial_data_in_o = tx_frame_i.right[15 - pos];
  end
  always @(negedge serial_clk_i) begin
    if (cnt >= 0) begin
      if (pos >= 16) pad_bad_o = pad_bad_o | serial_data_out_i;
      else if (cnt < half) rx_frame_o.left[15 - pos] = serial_data_out_i;
      else rx_frame_o.right[15 - pos] = serial_data_out_i;
    end
  end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the serial audio port
`timescale 1ns/1ps
module testbench import csp_pkg::*; ();
  localparam int unsigned HC = 5;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic en = 1'b0;
  logic [1:0] ffmt = SF_64_PULSE;
  logic [1:0] dfmt = DF_16;
  csp_frame_t cap = '0;
  csp_frame_t tx = '0;
  csp_frame_t pb_frame;
  csp_frame_t rx;
  logic cap_take, pb_valid, serial_data_in, sclk, frame_sync_out, serial_data_out, pad_bad;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;

  csp_serial_port #(.HALF_CYC(HC)) u_dut (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .serial_port_enable_bit_i(en),
    .frame_fmt_i(ffmt), .data_fmt_i(dfmt), .cap_frame_i(cap),
    .cap_take_o(cap_take), .pb_frame_o(pb_frame), .pb_valid_o(pb_valid),
    .serial_data_in_i(serial_data_in), .serial_clk_o(sclk),
    .frame_sync_out_o(frame_sync_out), .serial_data_out_o(serial_data_out));
  csp_dsp_model u_dsp (.serial_clk_i(sclk), .frame_sync_i(frame_sync_out),
    .serial_data_out_i(serial_data_out), .serial_data_in_o(serial_data_in), .active_i(en),
    .pulse_mode_i(ffmt == SF_64_PULSE), .bits64_i(ffmt != SF_32_LEVEL),
    .tx_frame_i(tx), .rx_frame_o(rx), .pad_bad_o(pad_bad));

  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end
  // three runs need about 3100 cycles; the ceiling leaves wide margin
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // enable, judge sync over the first frame and data from the second, then disable and watch the pins
  task automatic run(string name, logic [1:0] ff, logic [1:0] df,
                     logic [15:0] msk, int bits, int sync_cyc);
    int per;
    int hi;
    int t;
    per = bits * 2 * HC;
    ffmt = ff;
    dfmt = df;
    en = 1'b1;
    t = 0;
    while (cap_take !== 1'b1 && t < 200) begin
      @(negedge core_clk_i);
      t++;
    end
    check("frame start", 1, t < 200);
    // a window one frame long sees one frame of sync, wherever it starts
    repeat (5) @(negedge core_clk_i);
    hi = 0;
    t = -1;
    for (int i = 0; i < per; i++) begin
      if (frame_sync_out === 1'b1) hi++;
      if (cap_take === 1'b1) t = i;
      @(negedge core_clk_i);
    end
    check("sync high cycles", sync_cyc, hi);
    check("next frame start", per - 5, t);
    t = 0;
    while (pb_valid !== 1'b1 && t < per) begin
      @(negedge core_clk_i);
      t++;
    end
    check("playback valid", 1, t < per);
    check("playback", {tx.left & msk, tx.right & msk}, pb_frame);
    check("capture", {cap.left & msk, cap.right & msk}, rx);
    check("pad bits", 0, pad_bad);
    en = 1'b0;
    repeat (3) @(negedge core_clk_i);
    t = 0;
    repeat (50) begin
      if ({sclk, frame_sync_out, serial_data_out, pb_valid} !== 4'h0) t++;
      @(negedge core_clk_i);
    end
    check("idle pins", 0, t);
    $display("done %s", name);
  endtask

  task automatic t_pulse64();
    cap = {16'ha5c3, 16'h3c69};
    tx = {16'h9b2d, 16'h6e14};
    run("pulse 64 word", SF_64_PULSE, DF_16, MASK_16, 64, 2 * HC);
  endtask

  task automatic t_level64_byte();
    cap = {16'h5a3c, 16'hc396};
    tx = {16'h8100, 16'h7e00};
    run("level 64 byte", SF_64_LEVEL, DF_8, MASK_8, 64, 320);
  endtask

  task automatic t_level32_nib();
    cap = {16'hffff, 16'h1234};
    tx = {16'ha000, 16'h5000};
    run("level 32 nibble", SF_32_LEVEL, DF_4, MASK_4, 32, 160);
  endtask

  initial begin
    repeat (10) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    repeat (5) @(negedge core_clk_i);
    check("reset idle", 0, {sclk, frame_sync_out, serial_data_out, cap_take, pb_valid});
    t_pulse64();
    t_level64_byte();
    t_level32_nib();
    conclude();
  end
endmodule
